//--- design/gla_acceptor.sv
`timescale 1ns/10ps
`include "gla_defs.svh"

module gla_acceptor
   import gla_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // bus lines, active low
   input  wire logic [7:0] dio_b,
   input  wire logic       atn_b,
   input  wire logic       dav_b,
   // open-drain handshake drives, enable low pulls the line low
   output logic            nrfd_oe_b,
   output logic            ndac_oe_b,
   // bytes to the listener logic
   gla_byte_if.acceptor    bytes
);

   gla_acc_regs_t r_q;
   gla_acc_regs_t r_d;
   logic          take_part;

   // attention always forces us into the handshake; data only while listening
   assign take_part = !atn_b || bytes.active;

   // three-wire acceptor; not ready is held from each byte taken until the source drops data valid
   always_comb begin
      r_d        = r_q;
      r_d.strobe = 1'b0;
      case (r_q.st)
         ACC_IDLE: begin
            r_d.nrfd_oe_b = 1'b1;
            r_d.ndac_oe_b = 1'b1;
            if (take_part) begin
               r_d.ndac_oe_b = 1'b0;
               r_d.st        = ACC_READY;
            end
         end
         ACC_READY: begin
            if (!take_part) begin
               r_d.st = ACC_IDLE;
            end else if (!dav_b) begin
               r_d.data      = ~dio_b;
               r_d.atn       = !atn_b;
               r_d.strobe    = 1'b1;
               r_d.nrfd_oe_b = 1'b0;
               r_d.ndac_oe_b = 1'b1;
               r_d.st        = ACC_TAKEN;
            end
         end
         ACC_TAKEN: begin
            if (dav_b) begin
               r_d.ndac_oe_b = 1'b0;
               r_d.nrfd_oe_b = 1'b1;
               r_d.st        = ACC_READY;
            end
         end
         default: r_d.st = ACC_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         r_q <= '{st: ACC_IDLE, data: 8'h00, atn: 1'b0, strobe: 1'b0,
                  nrfd_oe_b: 1'b1, ndac_oe_b: 1'b1};
      end else begin
         r_q <= r_d;
      end
   end

   assign bytes.data   = r_q.data;
   assign bytes.atn    = r_q.atn;
   assign bytes.strobe = r_q.strobe;
   assign nrfd_oe_b    = r_q.nrfd_oe_b;
   assign ndac_oe_b    = r_q.ndac_oe_b;

endmodule

//--- design/gla_byte_if.sv
`timescale 1ns/10ps

// bytes taken by the acceptor and handed to the listener logic
interface gla_byte_if;
   logic [7:0] data;
   logic       atn;
   logic       strobe;
   logic       active;

   modport acceptor (output data, output atn, output strobe, input active);
   modport consumer (input data, input atn, input strobe, output active);
endinterface

//--- design/gla_defs.svh
`ifndef GLA_DEFS_SVH
`define GLA_DEFS_SVH

// listen address after reset
`define GLA_ADDR_RESET   5'h07
// interface command bytes, seven bits, sent with the attention line true
`define GLA_LAG_BASE     2'h1
`define GLA_LAG_POS      5
`define GLA_UNL          7'h3F
`define GLA_CMD_GTL      7'h01
`define GLA_CMD_SDC      7'h04
`define GLA_CMD_LLO      7'h11
`define GLA_CMD_DCL      7'h14
// program code characters, upper case
`define GLA_CH_F         7'h46
`define GLA_CH_R         7'h52
`define GLA_CH_M         7'h4D
`define GLA_CH_Z         7'h5A
`define GLA_CH_0         7'h30
`define GLA_CH_9         7'h39
`define GLA_CH_LOWER     7'h60
`define GLA_CASE_MASK    7'h5F
// initialised settings: carrier in MHz, amplitude in tenths of dBm (-127.0)
`define GLA_FREQ_RESET   10'h064
`define GLA_AMPL_RESET   16'hFB0A

`endif

//--- design/gla_listener.sv
`timescale 1ns/10ps
`include "gla_defs.svh"

// Functional notes
// - only the seven low data lines are decoded; the top line is ignored
// - listener only: accepts bytes, never talks or drives data lines
// - listen address is seven after reset until software loads another
// - own address with remote enable false: addressed, stays local
// - another listen address unaddresses; addressed indicator goes off, remote indicator unchanged
// - remote enable true plus own address: remote and addressed, both lit
// - remote enable first, address later, still completes the remote transition
// - addressed go-to-local returns to local, stays addressed
// - local key in remote without lockout returns to local, stays addressed
// - addressed data bytes execute; frequency code, digits, megahertz sets carrier
// - reset leaves local, unaddressed, default settings
// - in remote all panel keys except local are blocked
// - after lockout the local key is ignored, remote stays
// - clear restores default settings, remote and addressed unchanged
module gla_listener
   import gla_pkg::*;
#(
   parameter int KEYS = 16
)(
   // clock and reset
   input  wire logic            mclk,
   input  wire logic            rst_b,
   // bus lines, active low, synchronous to mclk
   input  wire logic [7:0]      dio_b,
   input  wire logic            atn_b,
   input  wire logic            dav_b,
   input  wire logic            ren_b,
   input  wire logic            ifc_b,
   // open-drain handshake drives, value low while enabled
   output logic                 nrfd_o,
   output logic                 nrfd_oe_b,
   output logic                 ndac_o,
   output logic                 ndac_oe_b,
   // listen address setting
   input  wire logic            addr_load,
   input  wire logic [4:0]      addr_val,
   // front panel
   input  wire logic            local_key,
   input  wire logic [KEYS-1:0] panel_key_in,
   output logic [KEYS-1:0]      panel_key_out,
   // indicators
   output logic                 remote_indicator,
   output logic                 addressed_indicator,
   output logic                 lockout,
   // program code stream and settings
   output logic [6:0]           code_byte,
   output logic                 code_valid,
   output logic                 settings_init,
   output logic [9:0]           carrier_mhz,
   output logic [15:0]          ampl_tenth_dbm
);

   // all listener state in one record; the acceptor keeps its own
   typedef struct packed {
      logic [4:0]      addr;
      logic            listen;
      logic            remote;
      logic            llo;
      logic [KEYS-1:0] keys;
      logic [6:0]      code;
      logic            code_v;
      logic            init;
      gla_pc_state_t   pc;
      logic [9:0]      acc;
      logic [9:0]      freq;
      logic [15:0]     ampl;
   } gla_lst_regs_t;

   // state and its next value
   gla_lst_regs_t s_q;
   gla_lst_regs_t s_d;
   gla_byte_if    bytes ();
   logic [6:0]    b7;
   logic [6:0]    ch;
   logic          is_digit;
   logic [13:0]   acc_next;

   gla_acceptor u_acc (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .dio_b     (dio_b),
      .atn_b     (atn_b),
      .dav_b     (dav_b),
      .nrfd_oe_b (nrfd_oe_b),
      .ndac_oe_b (ndac_oe_b),
      .bytes     (bytes)
   );

   // only a listening device joins data handshakes; commands are always taken
   assign bytes.active = s_q.listen;

   assign b7       = bytes.data[6:0];
   // program codes arrive in either case; fold letters to upper
   assign ch       = (b7 >= `GLA_CH_LOWER) ? (b7 & `GLA_CASE_MASK) : b7;
   assign is_digit = (ch >= `GLA_CH_0) && (ch <= `GLA_CH_9);
   // widened so ten times the accumulator cannot wrap before the cut
   assign acc_next = {4'h0, s_q.acc} * 14'd10 + {7'h00, ch - `GLA_CH_0};

   // one decision per cycle: bus byte first, then panel key, then management lines
   // later assignments win, so remote enable false and interface clear override a byte
   always_comb begin
      s_d        = s_q;
      s_d.code_v = 1'b0;
      s_d.init   = 1'b0;

      if (addr_load) begin
         s_d.addr = addr_val;
      end

      if (bytes.strobe && bytes.atn) begin
         // interface commands; our own address is checked first
         // unlisten shares the group, so it is never taken as our own address
         if (b7[6:5] == `GLA_LAG_BASE && b7[4:0] == s_q.addr && b7 != `GLA_UNL) begin
            s_d.listen = 1'b1;
            if (!ren_b) begin
               s_d.remote = 1'b1;
            end
         end else if (b7[6:5] == `GLA_LAG_BASE) begin
            s_d.listen = 1'b0;
         end else if (b7 == `GLA_CMD_GTL && s_q.listen) begin
            s_d.remote = 1'b0;
         end else if (b7 == `GLA_CMD_LLO) begin
            // lockout held until remote enable goes false
            s_d.llo = 1'b1;
         end else if (b7 == `GLA_CMD_DCL || (b7 == `GLA_CMD_SDC && s_q.listen)) begin
            s_d.init = 1'b1;
            s_d.freq = `GLA_FREQ_RESET;
            s_d.ampl = `GLA_AMPL_RESET;
            s_d.pc   = PC_IDLE;
         end
      end else if (bytes.strobe && s_q.listen) begin
         // data bytes passed on and scanned
         s_d.code   = b7;
         s_d.code_v = 1'b1;
         // scanner restarts on any byte it does not expect; a stray code never half-commits
         case (s_q.pc)
            PC_IDLE: begin
               s_d.pc = (ch == `GLA_CH_F) ? PC_GOT_F : PC_IDLE;
            end
            PC_GOT_F: begin
               s_d.pc  = (ch == `GLA_CH_R) ? PC_DIGITS : PC_IDLE;
               s_d.acc = 10'h000;
            end
            PC_DIGITS: begin
               // values above 1023 wrap at ten bits; no range check is made
               if (is_digit) begin
                  s_d.acc = acc_next[9:0];
               end else begin
                  s_d.pc = (ch == `GLA_CH_M) ? PC_GOT_M : PC_IDLE;
               end
            end
            PC_GOT_M: begin
               if (ch == `GLA_CH_Z) begin
                  s_d.freq = s_q.acc;
               end
               s_d.pc = PC_IDLE;
            end
            default: s_d.pc = PC_IDLE;
         endcase
      end

      // local key honoured only without lockout
      if (local_key && s_q.remote && !s_q.llo) begin
         s_d.remote = 1'b0;
      end

      // remote enable false forces local and clears lockout
      if (ren_b) begin
         s_d.remote = 1'b0;
         s_d.llo    = 1'b0;
      end

      // interface clear aborts listening
      // the abort leaves remote alone; remote enable false, go-to-local or the local key ends it
      if (!ifc_b) begin
         s_d.listen = 1'b0;
      end

      // keys follow the next remote state so gating never lags the indicator
      // panel keys blocked in remote; local key is a separate input
      s_d.keys = s_d.remote ? '0 : panel_key_in;
   end

   // reset gives local, unaddressed, default settings
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{addr: `GLA_ADDR_RESET, listen: 1'b0, remote: 1'b0, llo: 1'b0,
                  keys: '0, code: 7'h00, code_v: 1'b0, init: 1'b0, pc: PC_IDLE,
                  acc: 10'h000, freq: `GLA_FREQ_RESET, ampl: `GLA_AMPL_RESET};
      end else begin
         s_q <= s_d;
      end
   end

   // every output is a register bit or a constant tie
   // open-drain lines only ever pull low
   assign nrfd_o              = 1'b0;
   assign ndac_o              = 1'b0;
   assign panel_key_out       = s_q.keys;
   assign remote_indicator    = s_q.remote;
   assign addressed_indicator = s_q.listen;
   assign lockout             = s_q.llo;
   assign code_byte           = s_q.code;
   assign code_valid          = s_q.code_v;
   assign settings_init       = s_q.init;
   assign carrier_mhz         = s_q.freq;
   assign ampl_tenth_dbm      = s_q.ampl;

endmodule

//--- design/gla_pkg.sv
package gla_pkg;

   // acceptor handshake phases
   typedef enum logic [1:0] {
      ACC_IDLE,
      ACC_READY,
      ACC_TAKEN
   } gla_acc_state_t;

   // program code scanner phases
   typedef enum logic [2:0] {
      PC_IDLE,
      PC_GOT_F,
      PC_DIGITS,
      PC_GOT_M
   } gla_pc_state_t;

   typedef struct packed {
      gla_acc_state_t st;
      logic [7:0]     data;
      logic           atn;
      logic           strobe;
      logic           nrfd_oe_b;
      logic           ndac_oe_b;
   } gla_acc_regs_t;

endpackage

//--- tb/gla_ctrl_model.sv
`timescale 1ns/10ps
// bus controller: sources bytes and drives the management lines
module gla_ctrl_model (
   // clock
   input  wire logic  mclk,
   // acceptor drives
   input  wire logic  nrfd_oe_b,
   input  wire logic  ndac_oe_b,
   // controller lines, active low
   output logic [7:0] dio_b,
   output logic       atn_b,
   output logic       dav_b,
   output logic       ren_b,
   output logic       ifc_b
);
   int fails;

   // idle bus at time zero
   initial begin
      dio_b = 8'hFF;
      atn_b = 1'b1;
      dav_b = 1'b1;
      ren_b = 1'b1;
      ifc_b = 1'b1;
      fails = 0;
   end

   task automatic set_ren(input logic on);
      @(negedge mclk);
      ren_b = !on;
   endtask

   // bus abort line, active low
   task automatic set_ifc(input logic on);
      @(negedge mclk);
      ifc_b = !on;
   endtask

   // source side, waits bounded so a dead acceptor cannot hang us
   task automatic send(input logic atn, input logic [6:0] b);
      int n;
      @(negedge mclk);
      atn_b = !atn;
      dio_b = ~{b[0], b};
      for (n = 0; n < 50 && !(ndac_oe_b === 1'b0 && nrfd_oe_b === 1'b1); n++) begin
         @(negedge mclk);
      end
      dav_b = 1'b0;
      for (n = n; n < 100 && nrfd_oe_b !== 1'b0; n++) begin
         @(negedge mclk);
      end
      if (n >= 50) begin
         fails++;
      end
      dav_b = 1'b1;
      // released lines must not look like the old byte
      dio_b = ~dio_b;
      repeat (3) @(negedge mclk);
   endtask
endmodule

//--- tb/gla_props.sv
`timescale 1ns/10ps
// watches handshake drives, indicators and panel gating of the listener
module gla_props #(
   parameter int KEYS = 16
)(
   // clock and reset
   input wire logic            mclk,
   input wire logic            rst_b,
   // bus side
   input wire logic            dav_b,
   input wire logic            ren_b,
   input wire logic            nrfd_oe_b,
   input wire logic            ndac_oe_b,
   // panel and state
   input wire logic            local_key,
   input wire logic [KEYS-1:0] panel_key_out,
   input wire logic            remote_indicator,
   input wire logic            addressed_indicator,
   input wire logic            lockout,
   input wire logic            code_valid,
   input wire logic            settings_init
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   take_byte_a:
      assert property (!ndac_oe_b && nrfd_oe_b && !dav_b |=> !nrfd_oe_b && ndac_oe_b) else $error("byte not taken");
   hold_busy_a:
      assert property (!nrfd_oe_b && !dav_b |=> !nrfd_oe_b) else $error("not ready dropped early");
   release_busy_a:
      assert property (!nrfd_oe_b && dav_b |=> nrfd_oe_b) else $error("not ready held after release");
   remote_addr_a:
      assert property ($rose(remote_indicator) |-> addressed_indicator) else $error("remote without address");
   ren_local_a:
      assert property (ren_b |=> !remote_indicator && !lockout) else $error("remote with enable false");
   panel_block_a:
      assert property (remote_indicator && $past(remote_indicator) |-> panel_key_out == '0) else $error("keys live");
   key_local_a:
      assert property (local_key && remote_indicator && !lockout |=> !remote_indicator) else $error("key ignored");
   lockout_key_a:
      assert property (local_key && lockout && remote_indicator && !ren_b |=> remote_indicator) else $error("lockout");
   valid_pulse_a:
      assert property (code_valid |=> !code_valid) else $error("code valid too long");
   clear_keep_a:
      assert property (settings_init |-> $stable(remote_indicator) && $stable(addressed_indicator))
         else $error("clear changed state");
endmodule

bind gla_listener gla_props #(.KEYS(KEYS)) u_props (.mclk, .rst_b, .dav_b, .ren_b, .nrfd_oe_b, .ndac_oe_b,
   .local_key, .panel_key_out, .remote_indicator, .addressed_indicator, .lockout, .code_valid, .settings_init);

//--- tb/tb_ieee488_listener_remote_local.sv
`timescale 1ns/10ps
module tb_ieee488_listener_remote_local;
   logic        mclk, rst_b, addr_load, local_key;
   logic [4:0]  addr_val;
   logic [15:0] pk_in, pk_out, ampl_tenth_dbm;
   logic [7:0]  dio_b;
   logic        atn_b, dav_b, ren_b, ifc_b, nrfd_o, nrfd_oe_b, ndac_o, ndac_oe_b;
   logic        remote_indicator, addressed_indicator, lockout, code_valid, settings_init;
   logic [6:0]  code_byte, last_code;
   logic [9:0]  carrier_mhz;
   int          mismatches, num_checks, init_cnt;

   gla_listener dut (.mclk, .rst_b, .dio_b, .atn_b, .dav_b, .ren_b, .ifc_b, .nrfd_o, .nrfd_oe_b, .ndac_o,
      .ndac_oe_b, .addr_load, .addr_val, .local_key, .panel_key_in(pk_in), .panel_key_out(pk_out),
      .remote_indicator, .addressed_indicator, .lockout, .code_byte, .code_valid, .settings_init,
      .carrier_mhz, .ampl_tenth_dbm);
   gla_ctrl_model ctl (.mclk, .nrfd_oe_b, .ndac_oe_b, .dio_b, .atn_b, .dav_b, .ren_b, .ifc_b);

   always #12.5 mclk = ~mclk;

   // pulses are one cycle wide, so latch them here
   always @(posedge mclk) begin
      if (code_valid === 1'b1) last_code <= code_byte;
      if (settings_init === 1'b1) init_cnt <= init_cnt + 1;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic ind(input logic r, input logic a);
      chk({remote_indicator, addressed_indicator}, {r, a});
   endtask

   task automatic do_reset();
      rst_b = 1'b0;
      repeat (12) @(negedge mclk);
      rst_b = 1'b1;
      @(negedge mclk);
   endtask

   task automatic press();
      @(negedge mclk);
      local_key = 1'b1;
      @(negedge mclk);
      local_key = 1'b0;
      repeat (2) @(negedge mclk);
   endtask

   task automatic t_addr();
      ind(0, 0);
      chk(carrier_mhz, 10'h064);
      chk(ampl_tenth_dbm, 16'hFB0A);
      chk(nrfd_o, 1'b0);
      chk(ndac_o, 1'b0);
      ctl.send(1, 7'h27);
      ind(0, 1);
      ctl.send(1, 7'h2F);
      ind(0, 0);
      @(negedge mclk);
      addr_val = 5'h0A;
      addr_load = 1'b1;
      @(negedge mclk);
      addr_load = 1'b0;
      ctl.send(1, 7'h2A);
      ind(0, 1);
   endtask

   task automatic t_remote();
      do_reset();
      ctl.set_ren(1);
      ctl.send(1, 7'h27);
      ind(1, 1);
      pk_in = 16'hFFFF;
      repeat (2) @(negedge mclk);
      chk(pk_out, 16'h0000);
      ctl.send(1, 7'h01);
      ind(0, 1);
      chk(pk_out, 16'hFFFF);
      ctl.send(1, 7'h27);
      ind(1, 1);
      press();
      ind(0, 1);
   endtask

   task automatic t_lockout();
      do_reset();
      ctl.set_ren(1);
      ctl.send(1, 7'h11);
      ctl.send(1, 7'h27);
      chk(lockout, 1'b1);
      press();
      ind(1, 1);
      ctl.set_ifc(1);
      ctl.set_ifc(0);
      @(negedge mclk);
      chk(addressed_indicator, 1'b0);
   endtask

   // lower case codes after a remote enable sent ahead of the address
   task automatic t_data_clear();
      string s;
      byte   c;
      int    n;
      s = "fr990mz";
      do_reset();
      ctl.set_ren(1);
      repeat (3) @(negedge mclk);
      ind(0, 0);
      ctl.send(1, 7'h27);
      for (int i = 0; i < s.len(); i++) begin
         c = s[i];
         ctl.send(0, c[6:0]);
         chk(last_code, c[6:0]);
      end
      ind(1, 1);
      chk(carrier_mhz, 10'h3DE);
      n = init_cnt;
      ctl.send(1, 7'h04);
      chk(16'(init_cnt - n), 16'h0001);
      chk(carrier_mhz, 10'h064);
      chk(ampl_tenth_dbm, 16'hFB0A);
      ind(1, 1);
      ctl.send(1, 7'h3F);
      chk(addressed_indicator, 1'b0);
      ctl.send(1, 7'h14);
      chk(16'(init_cnt - n), 16'h0002);
      do_reset();
      ind(0, 0);
   endtask

   task automatic wrap_up();
      mismatches += ctl.fails;
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      {mclk, addr_load, local_key, addr_val, pk_in} = '0;
      {mismatches, num_checks, init_cnt} = '0;
      do_reset();
      t_addr();
      t_remote();
      t_lockout();
      t_data_clear();
      wrap_up();
   end

   // tests need well under 2000 cycles; ten times that means a hang
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      wrap_up();
   end
endmodule
